// file: dpcb_ctrl.sv
module dpcb_ctrl
(
    // Clock and reset
    input  wire logic       CLOCK,
    input  wire logic       RESET_N,
    // Processor bus
    input  wire logic       CS,
    input  wire logic       ALE,
    input  wire logic       RD_N,
    input  wire logic       WR_N,
    input  wire logic [7:0] AD_IN,
    output logic      [7:0] AD_OUT,
    output logic            AD_OE,
    // Buffer RAM
    output logic      [7:0] BUF_ADDR_LO,
    output logic            HOST_HI_ADDR_STROBE,
    output logic            PERIPH_HI_ADDR_STROBE,
    output logic      [1:0] BUF_ADDR_MID,
    output logic            HOST_HI_ADDR_ENABLE_N,
    output logic            PERIPH_HI_ADDR_ENABLE_N,
    output logic            RAM_SELECT_N,
    output logic            RAM_WRITE_N,
    // Peripheral port
    input  wire logic       PERIPHERAL_TRANSFER_REQUEST_N,
    // Host port
    output logic            HOST_IN_DRIVE_N,
    output logic            HOST_OUT_DRIVE_N,
    output logic            HOST_OUTPUT_HOLD,
    output logic            HOST_TRANSFER_REQUEST,
    input  wire logic       HOST_ACK,
    // Bus arbitration
    output logic            BUSY_DRIVE_OUT,
    input  wire logic       BUSY_SENSE_IN,
    output logic            SELECT_DRIVE_OUT,
    input  wire logic       SELECT_SENSE_IN,
    output logic            RESPONDER_ROLE_N,
    output logic            ORIGINATOR_ROLE_N
);

    // All pins are asynchronous, so the whole bundle goes through three flops.
    dpcb_pkg::dpcb_pins_t   pins_in;
    dpcb_pkg::dpcb_pins_t   p_s1_ff;
    dpcb_pkg::dpcb_pins_t   p_s2_ff;
    dpcb_pkg::dpcb_pins_t   p_s3_ff;
    dpcb_pkg::dpcb_state_t  state_ff;
    dpcb_pkg::dpcb_state_t  nxt_state;

    logic [7:0]  addr_ff;
    logic [7:0]  ifc_ff;
    logic [7:0]  xfc_ff;
    logic [7:0]  size_ff;
    logic [7:0]  amode_ff;
    logic        srst_ff;
    logic        done_ff;
    logic        arb_won_ff;
    logic [15:0] rp_ff;
    logic [15:0] wp_ff;
    logic [15:0] sp_ff;
    logic [15:0] nxt_rp;
    logic [15:0] nxt_wp;
    logic [15:0] nxt_sp;
    logic        host_pend_ff;
    logic        host_rel_ff;
    logic        port_b_ff;
    logic        nxt_port_b;
    logic [7:0]  hi_a_ff;
    logic [7:0]  hi_b_ff;
    logic        hi_a_vld_ff;
    logic        hi_b_vld_ff;

    assign pins_in = '{ale: ALE, rd_n: RD_N, wr_n: WR_N, cs: CS, ad: AD_IN,
                       peripheral_transfer_request_n_n: PERIPHERAL_TRANSFER_REQUEST_N, back: HOST_ACK,
                       busy_in: BUSY_SENSE_IN, sel_in: SELECT_SENSE_IN};

    always_ff @(posedge CLOCK)
    begin
        p_s1_ff <= pins_in;
        p_s2_ff <= p_s1_ff;
        p_s3_ff <= p_s2_ff;
    end

    // Processor side decode.
    wire        ale_fall  = p_s3_ff.ale & ~p_s2_ff.ale;
    wire        cs_on     = p_s2_ff.cs;
    wire        wr_take   = p_s3_ff.wr_n & ~p_s2_ff.wr_n & cs_on;
    wire        rd_act    = ~p_s2_ff.rd_n & cs_on;
    wire        wr_act    = ~p_s2_ff.wr_n & cs_on;
    wire [7:0]  wdat      = p_s2_ff.ad;
    wire        live      = ~srst_ff;
    wire        w_ifc     = wr_take & live & (addr_ff == dpcb_pkg::OFS_IFC);
    wire        w_xfc     = wr_take & live & (addr_ff == dpcb_pkg::OFS_XFC);
    wire        w_size    = wr_take & live & (addr_ff == dpcb_pkg::OFS_SIZE);
    wire        w_amode   = wr_take & live & (addr_ff == dpcb_pkg::OFS_AMODE);
    wire        w_srst    = wr_take & (addr_ff == dpcb_pkg::OFS_SRST);
    wire        w_rpl     = wr_take & live & (addr_ff == dpcb_pkg::OFS_RPL);
    wire        w_rph     = wr_take & live & (addr_ff == dpcb_pkg::OFS_RPH);
    wire        w_wpl     = wr_take & live & (addr_ff == dpcb_pkg::OFS_WPL);
    wire        w_wph     = wr_take & live & (addr_ff == dpcb_pkg::OFS_WPH);
    wire        w_spl     = wr_take & live & (addr_ff == dpcb_pkg::OFS_SPL);
    wire        w_sph     = wr_take & live & (addr_ff == dpcb_pkg::OFS_SPH);
    wire        w_stop    = w_spl | w_sph;
    wire        ptr_clr   = w_srst & ~srst_ff;
    wire        host_loc  = (addr_ff == dpcb_pkg::OFS_HOST_LO) | (addr_ff == dpcb_pkg::OFS_HOST_HI);

    // Transfer control decode.
    wire        dir       = xfc_ff[dpcb_pkg::XFC_DIR];
    wire        up_en     = xfc_ff[dpcb_pkg::XFC_UP] & dir;
    wire        down_en   = xfc_ff[dpcb_pkg::XFC_DOWN] & ~dir;
    wire [15:0] ptr_a     = dir ? wp_ff : rp_ff;
    wire [15:0] ptr_b     = dir ? rp_ff : wp_ff;
    wire        b_at_stop = (ptr_b == sp_ff);
    wire        host_go   = (up_en | down_en) & ~b_at_stop;
    wire        peripheral_transfer_request_n_on   = ~p_s2_ff.peripheral_transfer_request_n_n;
    wire        ack_on    = p_s2_ff.back;
    wire [15:0] len_last  = {size_ff, dpcb_pkg::LEN_LOW_LAST};

    // Addressing mode.
    wire        wide      = amode_ff[dpcb_pkg::AMODE_WIDE];
    wire        dir10     = ~wide & (size_ff <= dpcb_pkg::DIR10_MAX);
    wire        dir14     = wide & (size_ff <= dpcb_pkg::DIR14_MAX);
    wire        ext       = ~(dir10 | dir14);
    wire        need_a    = ext & ~(hi_a_vld_ff & (hi_a_ff == ptr_a[15:8]));
    wire        need_b    = ext & ~(hi_b_vld_ff & (hi_b_ff == ptr_b[15:8]));

    function automatic logic [15:0] ptr_inc(input logic [15:0] p, input logic [15:0] last);
        ptr_inc = (p == last) ? dpcb_pkg::PTR_RST : p + 16'h0001;
    endfunction

    always_ff @(posedge CLOCK)
    begin
        if (!RESET_N)
            addr_ff <= 8'h00;
        else if (ale_fall)
            addr_ff <= p_s2_ff.ad;
    end

    // Soft reset bit; while set the control, pointer, state, latch, handshake and arbitration registers are held at reset.
    always_ff @(posedge CLOCK)
    begin
        if (!RESET_N)
            srst_ff <= dpcb_pkg::SRST_RST;
        else if (w_srst)
            srst_ff <= wdat[dpcb_pkg::SRST_BIT];
    end

    always_ff @(posedge CLOCK)
    begin
        if (!RESET_N || srst_ff)
        begin
            ifc_ff   <= dpcb_pkg::IFC_RST;
            xfc_ff   <= dpcb_pkg::XFC_RST;
            size_ff  <= dpcb_pkg::SIZE_RST;
            amode_ff <= dpcb_pkg::AMODE_RST;
        end
        else
        begin
            if (w_ifc)
                ifc_ff <= wdat;
            if (w_xfc)
                xfc_ff <= wdat;
            if (w_size)
                size_ff <= wdat;
            if (w_amode)
                amode_ff <= wdat;
        end
    end

    // Pointers: processor writes beat increments in the same cycle.
    wire inc_rp = ((state_ff == dpcb_pkg::ST_PERIPH) & ~dir) | ((state_ff == dpcb_pkg::ST_HOST) & dir);
    wire inc_wp = ((state_ff == dpcb_pkg::ST_PERIPH) & dir) | ((state_ff == dpcb_pkg::ST_HOST) & ~dir);

    always_comb
    begin
        nxt_rp = inc_rp ? ptr_inc(rp_ff, len_last) : rp_ff;
        nxt_wp = inc_wp ? ptr_inc(wp_ff, len_last) : wp_ff;
        nxt_sp = sp_ff;
        if (w_rpl)
            nxt_rp[7:0] = wdat;
        if (w_rph)
            nxt_rp[15:8] = wdat;
        if (w_wpl)
            nxt_wp[7:0] = wdat;
        if (w_wph)
            nxt_wp[15:8] = wdat;
        if (w_spl)
            nxt_sp[7:0] = wdat;
        if (w_sph)
            nxt_sp[15:8] = wdat;
        if (srst_ff || ptr_clr)
        begin
            nxt_rp = dpcb_pkg::PTR_RST;
            nxt_wp = dpcb_pkg::PTR_RST;
            nxt_sp = dpcb_pkg::PTR_RST;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (!RESET_N)
        begin
            rp_ff <= dpcb_pkg::PTR_RST;
            wp_ff <= dpcb_pkg::PTR_RST;
            sp_ff <= dpcb_pkg::PTR_RST;
        end
        else
        begin
            rp_ff <= nxt_rp;
            wp_ff <= nxt_wp;
            sp_ff <= nxt_sp;
        end
    end

    // Access sequencer. Each byte takes an access cycle and an idle cycle.
    always_comb
    begin
        nxt_state  = dpcb_pkg::ST_IDLE;
        nxt_port_b = port_b_ff;
        case (state_ff)
            dpcb_pkg::ST_IDLE:
            begin
                if (peripheral_transfer_request_n_on)
                begin
                    nxt_port_b = 1'b0;
                    nxt_state  = need_a ? dpcb_pkg::ST_LATCH_SET : dpcb_pkg::ST_PERIPH;
                end
                else if (host_pend_ff && ack_on)
                begin
                    nxt_port_b = 1'b1;
                    nxt_state  = need_b ? dpcb_pkg::ST_LATCH_SET : dpcb_pkg::ST_HOST;
                end
            end
            dpcb_pkg::ST_LATCH_SET:
                nxt_state = dpcb_pkg::ST_LATCH_CLK;
            dpcb_pkg::ST_LATCH_CLK:
                nxt_state = port_b_ff ? dpcb_pkg::ST_HOST : dpcb_pkg::ST_PERIPH;
            default:
                nxt_state = dpcb_pkg::ST_IDLE;
        endcase
        if (srst_ff)
            nxt_state = dpcb_pkg::ST_IDLE;
    end

    always_ff @(posedge CLOCK)
    begin
        if (!RESET_N)
        begin
            state_ff  <= dpcb_pkg::ST_IDLE;
            port_b_ff <= 1'b0;
        end
        else
        begin
            state_ff  <= nxt_state;
            port_b_ff <= nxt_port_b;
        end
    end

    // Upper-byte latch shadows; in extended addressing a pointer whose upper byte differs from its shadow forces the two latch cycles again.
    always_ff @(posedge CLOCK)
    begin
        if (!RESET_N || srst_ff)
        begin
            hi_a_ff     <= 8'h00;
            hi_b_ff     <= 8'h00;
            hi_a_vld_ff <= 1'b0;
            hi_b_vld_ff <= 1'b0;
        end
        else if (state_ff == dpcb_pkg::ST_LATCH_CLK)
        begin
            if (port_b_ff)
            begin
                hi_b_ff     <= ptr_b[15:8];
                hi_b_vld_ff <= 1'b1;
            end
            else
            begin
                hi_a_ff     <= ptr_a[15:8];
                hi_a_vld_ff <= 1'b1;
            end
        end
    end

    // Host handshake: request held until the access, then wait for acknowledge to drop.
    always_ff @(posedge CLOCK)
    begin
        if (!RESET_N || srst_ff)
        begin
            host_pend_ff <= 1'b0;
            host_rel_ff  <= 1'b0;
        end
        else
        begin
            if (nxt_state == dpcb_pkg::ST_HOST)
                host_pend_ff <= 1'b0;
            else if (host_go && !host_rel_ff && !ack_on)
                host_pend_ff <= 1'b1;
            if (state_ff == dpcb_pkg::ST_HOST)
                host_rel_ff <= 1'b1;
            else if (!ack_on)
                host_rel_ff <= 1'b0;
        end
    end

    // Set wins over a stop write, but is judged on the incoming stop value, so moving the stop still clears.
    wire done_set = (up_en | down_en) & (ptr_b == nxt_sp) & ~host_pend_ff & ~ack_on;

    always_ff @(posedge CLOCK)
    begin
        if (!RESET_N || srst_ff)
            done_ff <= 1'b0;
        else if (done_set)
            done_ff <= 1'b1;
        else if (w_stop)
            done_ff <= 1'b0;
    end

    wire bus_free = ~p_s2_ff.busy_in & ~p_s2_ff.sel_in;

    always_ff @(posedge CLOCK)
    begin
        if (!RESET_N || srst_ff)
            arb_won_ff <= 1'b0;
        else
            arb_won_ff <= ifc_ff[dpcb_pkg::IFC_ARB] & (arb_won_ff | bus_free);
    end

    // Next values of the buffer pins, decoded from the next state.
    wire        acc_p     = (nxt_state == dpcb_pkg::ST_PERIPH);
    wire        acc_h     = (nxt_state == dpcb_pkg::ST_HOST);
    wire        lat_set   = (nxt_state == dpcb_pkg::ST_LATCH_SET);
    wire        lat_clk   = (nxt_state == dpcb_pkg::ST_LATCH_CLK);
    wire        lat_any   = lat_set | lat_clk;
    wire [15:0] cur_ptr   = nxt_port_b ? ptr_b : ptr_a;
    wire        acc_wr    = (acc_p & dir) | (acc_h & ~dir);
    wire [7:0]  nxt_lo    = lat_any ? cur_ptr[15:8] : cur_ptr[7:0];
    wire        nxt_a8    = ext ? (lat_clk & nxt_port_b) : cur_ptr[8];
    wire        nxt_a9    = ext ? (lat_clk & ~nxt_port_b) : cur_ptr[9];
    wire        nxt_a12   = ext ? ~(acc_h & ~lat_any) : cur_ptr[12];
    wire        nxt_a13   = ext ? ~(acc_p & ~lat_any) : cur_ptr[13];
    wire        up_acc    = acc_h & dir;
    wire        mpu_in    = rd_act & host_loc & ifc_ff[dpcb_pkg::IFC_IN_DRV];
    wire        mpu_out   = wr_act & host_loc & ifc_ff[dpcb_pkg::IFC_OUT_DRV];

    wire [7:0]  ifc_rd    = {ifc_ff[7:6], p_s2_ff.busy_in, p_s2_ff.sel_in,
                             ifc_ff[3:2], 1'b0, arb_won_ff};
    wire [7:0]  xfc_rd    = {xfc_ff[7:6], done_ff, xfc_ff[4:2], ack_on, 1'b0};
    wire [7:0]  rd_data   = (addr_ff == dpcb_pkg::OFS_IFC)  ? ifc_rd :
                            (addr_ff == dpcb_pkg::OFS_XFC)  ? xfc_rd :
                            (addr_ff == dpcb_pkg::OFS_SIZE) ? size_ff :
                            (addr_ff == dpcb_pkg::OFS_RPL)  ? rp_ff[7:0] :
                            (addr_ff == dpcb_pkg::OFS_RPH)  ? rp_ff[15:8] :
                            (addr_ff == dpcb_pkg::OFS_WPL)  ? wp_ff[7:0] :
                            (addr_ff == dpcb_pkg::OFS_WPH)  ? wp_ff[15:8] :
                            (addr_ff == dpcb_pkg::OFS_SPL)  ? sp_ff[7:0] :
                            (addr_ff == dpcb_pkg::OFS_SPH)  ? sp_ff[15:8] : 8'h00;

    // Pin flops. The RAM strobes are registered so each access lands on one edge.
    always_ff @(posedge CLOCK)
    begin
        if (!RESET_N)
        begin
            AD_OUT                  <= 8'h00;
            AD_OE                   <= 1'b0;
            BUF_ADDR_LO             <= 8'h00;
            HOST_HI_ADDR_STROBE     <= 1'b0;
            PERIPH_HI_ADDR_STROBE   <= 1'b0;
            BUF_ADDR_MID            <= 2'h0;
            HOST_HI_ADDR_ENABLE_N   <= 1'b1;
            PERIPH_HI_ADDR_ENABLE_N <= 1'b1;
            RAM_SELECT_N            <= 1'b1;
            RAM_WRITE_N             <= 1'b1;
            HOST_IN_DRIVE_N         <= 1'b1;
            HOST_OUT_DRIVE_N        <= 1'b1;
            HOST_OUTPUT_HOLD        <= 1'b0;
            HOST_TRANSFER_REQUEST   <= 1'b0;
            BUSY_DRIVE_OUT          <= 1'b0;
            SELECT_DRIVE_OUT        <= 1'b0;
            RESPONDER_ROLE_N        <= 1'b1;
            ORIGINATOR_ROLE_N       <= 1'b1;
        end
        else
        begin
            AD_OUT                  <= rd_data;
            AD_OE                   <= rd_act;
            BUF_ADDR_LO             <= nxt_lo;
            HOST_HI_ADDR_STROBE     <= nxt_a8;
            PERIPH_HI_ADDR_STROBE   <= nxt_a9;
            BUF_ADDR_MID            <= cur_ptr[11:10];
            HOST_HI_ADDR_ENABLE_N   <= nxt_a12;
            PERIPH_HI_ADDR_ENABLE_N <= nxt_a13;
            RAM_SELECT_N            <= ~(acc_p | acc_h);
            RAM_WRITE_N             <= ~acc_wr;
            HOST_IN_DRIVE_N         <= ~((acc_h & ~dir) | mpu_in);
            HOST_OUT_DRIVE_N        <= ~(up_acc | mpu_out | arb_won_ff);
            HOST_OUTPUT_HOLD        <= up_acc | mpu_out;
            HOST_TRANSFER_REQUEST   <= host_pend_ff & ~srst_ff & ~acc_h;
            BUSY_DRIVE_OUT          <= ifc_ff[dpcb_pkg::IFC_BUSY_OUT] | arb_won_ff;
            SELECT_DRIVE_OUT        <= ifc_ff[dpcb_pkg::IFC_SEL_OUT];
            RESPONDER_ROLE_N        <= ~xfc_ff[dpcb_pkg::XFC_RESP];
            ORIGINATOR_ROLE_N       <= ~xfc_ff[dpcb_pkg::XFC_ORIG];
        end
    end

endmodule

// file: dpcb_pkg.sv
package dpcb_pkg;

    localparam logic [7:0]  OFS_HOST_LO  = 8'h50;
    localparam logic [7:0]  OFS_HOST_HI  = 8'h51;
    localparam logic [7:0]  OFS_IFC      = 8'h52;
    localparam logic [7:0]  OFS_XFC      = 8'h53;
    localparam logic [7:0]  OFS_SIZE     = 8'h54;
    localparam logic [7:0]  OFS_AMODE    = 8'h55;
    localparam logic [7:0]  OFS_SRST     = 8'h59;
    localparam logic [7:0]  OFS_RPL      = 8'h5a;
    localparam logic [7:0]  OFS_RPH      = 8'h5b;
    localparam logic [7:0]  OFS_WPL      = 8'h5c;
    localparam logic [7:0]  OFS_WPH      = 8'h5d;
    localparam logic [7:0]  OFS_SPL      = 8'h5e;
    localparam logic [7:0]  OFS_SPH      = 8'h5f;

    localparam int IFC_BUSY_OUT = 7;
    localparam int IFC_SEL_OUT  = 6;
    localparam int IFC_OUT_DRV  = 3;
    localparam int IFC_IN_DRV   = 2;
    localparam int IFC_ARB      = 0;
    localparam int XFC_RESP     = 7;
    localparam int XFC_ORIG     = 6;
    localparam int XFC_DIR      = 4;
    localparam int XFC_UP       = 3;
    localparam int XFC_DOWN     = 2;
    localparam int AMODE_WIDE   = 0;
    localparam int SRST_BIT     = 0;

    localparam logic [7:0]  IFC_RST      = 8'h00;
    localparam logic [7:0]  XFC_RST      = 8'h00;
    localparam logic [7:0]  SIZE_RST     = 8'h00;
    localparam logic [7:0]  AMODE_RST    = 8'h00;
    localparam logic        SRST_RST     = 1'h1;
    localparam logic [15:0] PTR_RST      = 16'h0000;
    localparam logic [7:0]  LEN_LOW_LAST = 8'hff;
    localparam logic [7:0]  DIR10_MAX    = 8'h03;
    localparam logic [7:0]  DIR14_MAX    = 8'h3f;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_PERIPH    = 3'b001,
        ST_HOST      = 3'b010,
        ST_LATCH_SET = 3'b011,
        ST_LATCH_CLK = 3'b100
    } dpcb_state_t;

    typedef struct packed {
        logic       ale;
        logic       rd_n;
        logic       wr_n;
        logic       cs;
        logic [7:0] ad;
        logic       peripheral_transfer_request_n_n;
        logic       back;
        logic       busy_in;
        logic       sel_in;
    } dpcb_pins_t;

endpackage

// file: dpcb_ctrl_properties.sv
module dpcb_ctrl_properties
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RESET_N,
    // Watched pins
    input wire logic CS,
    input wire logic RD_N,
    input wire logic AD_OE,
    input wire logic RAM_SELECT_N,
    input wire logic RAM_WRITE_N,
    input wire logic PERIPHERAL_TRANSFER_REQUEST_N,
    input wire logic HOST_TRANSFER_REQUEST,
    input wire logic HOST_ACK,
    input wire logic HOST_IN_DRIVE_N,
    input wire logic HOST_OUT_DRIVE_N,
    input wire logic HOST_OUTPUT_HOLD
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESET_N);

    // Five samples cover two synchroniser stages and the output register.
    sequence rd_held;
        (CS && !RD_N) [*5];
    endsequence
    sequence host_access;
        !RAM_SELECT_N && !(HOST_IN_DRIVE_N && HOST_OUT_DRIVE_N);
    endsequence

    AST_READ_ANSWER: assert property (rd_held |-> AD_OE)
        else $error("read data not driven");
    AST_CHIP_SELECT: assert property ((!CS) [*5] |-> !AD_OE)
        else $error("bus driven without chip select");
    AST_ACCESS_PULSE: assert property ($fell(RAM_SELECT_N) |=> RAM_SELECT_N)
        else $error("access longer than one cycle");
    AST_WRITE_QUAL: assert property (!RAM_WRITE_N |-> !RAM_SELECT_N)
        else $error("write strobe without select");
    AST_PERIPH_SERVE: assert property ($fell(PERIPHERAL_TRANSFER_REQUEST_N) |-> ##[1:6] !RAM_SELECT_N)
        else $error("peripheral request not served");
    AST_HOST_DOWNLOAD: assert property (!RAM_SELECT_N && !HOST_IN_DRIVE_N |-> HOST_ACK && !RAM_WRITE_N)
        else $error("host write access without grant");
    AST_UPLOAD_HOLD: assert property (!RAM_SELECT_N && !HOST_OUT_DRIVE_N |-> HOST_OUTPUT_HOLD && RAM_WRITE_N)
        else $error("host read access without hold");
    AST_REQUEST_DROP: assert property ($fell(HOST_TRANSFER_REQUEST) |-> host_access)
        else $error("request dropped without access");
endmodule

bind dpcb_ctrl dpcb_ctrl_properties u_dpcb_ctrl_properties (.CLOCK(CLOCK), .RESET_N(RESET_N), .CS(CS),
    .RD_N(RD_N), .AD_OE(AD_OE), .RAM_SELECT_N(RAM_SELECT_N), .RAM_WRITE_N(RAM_WRITE_N),
    .PERIPHERAL_TRANSFER_REQUEST_N(PERIPHERAL_TRANSFER_REQUEST_N), .HOST_TRANSFER_REQUEST(HOST_TRANSFER_REQUEST),
    .HOST_ACK(HOST_ACK), .HOST_IN_DRIVE_N(HOST_IN_DRIVE_N), .HOST_OUT_DRIVE_N(HOST_OUT_DRIVE_N),
    .HOST_OUTPUT_HOLD(HOST_OUTPUT_HOLD));

// file: dpcb_host_model.sv
module dpcb_host_model
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // Handshake
    input  wire logic       request,
    input  wire logic [1:0] lag,
    output logic            ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       ack_ff;
    logic [1:0] wait_ff;

    // Ack falls only after the request is seen gone, so every byte costs a full handshake.
    always_ff @(posedge clock)
    begin
        if (!reset_n || !request)
        begin
            ack_ff  <= 1'b0;
            wait_ff <= 2'h0;
        end
        else if (wait_ff == lag)
            ack_ff <= 1'b1;
        else
            wait_ff <= wait_ff + 2'h1;
    end
    assign ack = ack_ff;
endmodule

// file: dpcb_ctrl_tb.sv
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module dpcb_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 clock = 1'b0;
    logic                 reset_n = 1'b0;
    // Idle bus: strobes high, request high, sense inputs busy and select high.
    dpcb_pkg::dpcb_pins_t pin = 16'h600b;
    logic [1:0]           lag = 2'h0;
    logic [7:0]           ad_out, addr_lo, v, hi;
    logic                 stb, penb_n, hold;
    logic [10:0]          e;
    logic                 ad_oe, oe_d, sel_n, ram_wr_n, in_n, out_n, req, ack, busy_o, sel_o, resp_n, orig_n;
    int                   errors, comparisons, cycles, drv;
    logic [7:0]           rdq[$];
    logic [10:0]          ramq[$];
    logic [7:0]           regs[5] = '{8'h52, 8'h53, 8'h54, 8'h55, 8'h56};

    dpcb_ctrl u_dpcb_ctrl (.CLOCK(clock), .RESET_N(reset_n), .CS(pin.cs), .ALE(pin.ale), .RD_N(pin.rd_n),
        .WR_N(pin.wr_n), .AD_IN(pin.ad), .AD_OUT(ad_out), .AD_OE(ad_oe), .BUF_ADDR_LO(addr_lo),
        .HOST_HI_ADDR_STROBE(), .PERIPH_HI_ADDR_STROBE(stb), .BUF_ADDR_MID(), .HOST_HI_ADDR_ENABLE_N(),
        .PERIPH_HI_ADDR_ENABLE_N(penb_n), .RAM_SELECT_N(sel_n), .RAM_WRITE_N(ram_wr_n),
        .PERIPHERAL_TRANSFER_REQUEST_N(pin.peripheral_transfer_request_n_n), .HOST_IN_DRIVE_N(in_n), .HOST_OUT_DRIVE_N(out_n),
        .HOST_OUTPUT_HOLD(hold), .HOST_TRANSFER_REQUEST(req), .HOST_ACK(ack), .BUSY_DRIVE_OUT(busy_o),
        .BUSY_SENSE_IN(pin.busy_in), .SELECT_DRIVE_OUT(sel_o), .SELECT_SENSE_IN(pin.sel_in),
        .RESPONDER_ROLE_N(resp_n), .ORIGINATOR_ROLE_N(orig_n));
    dpcb_host_model u_dpcb_host_model (.clock(clock), .reset_n(reset_n), .request(req), .lag(lag), .ack(ack));

    always #20 clock = ~clock;

    task automatic give_verdict();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Strobes are held five cycles because the bus is synchronised inside.
    task automatic acc(input bit rd, input logic [7:0] a, input logic [7:0] d, input bit c = 1'b1);
        if (rd && c)
            rdq.push_back(d);
        @(posedge clock);
        pin.cs  <= c;
        pin.ale <= 1'b1;
        pin.ad  <= a;
        @(posedge clock);
        pin.ale <= 1'b0;
        repeat (3) @(posedge clock);
        pin.ad   <= d;
        pin.rd_n <= !rd;
        pin.wr_n <= rd;
        repeat (5) @(posedge clock);
        pin.rd_n <= 1'b1;
        pin.wr_n <= 1'b1;
        repeat (4) @(posedge clock);
    endtask

    task automatic host(input bit up, input logic [7:0] n);
        acc(0, 8'h59, 8'h00);
        acc(0, 8'h53, {3'b000, up, up, !up, 2'b00});
        for (int i = 0; i < n; i++)
            ramq.push_back({up, up, !up, i[7:0]});
        lag <= 2'($urandom);
        acc(0, 8'h5e, n);
        repeat (150) @(posedge clock);
        acc(1, 8'h53, {2'b00, 1'b1, up, up, !up, 2'b00});
    endtask

    always @(posedge clock)
    begin
        oe_d <= ad_oe;
        if (ad_oe && !oe_d)
        begin
            e = {3'b000, rdq.pop_front()};
            `CHK(ad_out, e[7:0])
        end
        if (!sel_n)
        begin
            e = ramq.pop_front();
            `CHK({ram_wr_n, in_n, out_n, addr_lo}, e)
        end
        if (reset_n && sel_n && !busy_o)
            drv += int'(!in_n) + int'(!out_n) + int'(hold);
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            give_verdict();
        end
    end

    initial
    begin
        void'($urandom(32'h4f5e40af));
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        acc(0, 8'h54, 8'ha5);
        foreach (regs[i])
            acc(1, regs[i], regs[i] == 8'h52 ? 8'h30 : 8'h00);
        acc(0, 8'h59, 8'h00);
        v = 8'($urandom);
        acc(0, 8'h54, v);
        acc(0, 8'h54, ~v, 1'b0);
        acc(1, 8'h54, v, 1'b0);
        acc(1, 8'h54, v);
        acc(0, 8'h54, 8'h00);
        acc(0, 8'h52, 8'hc0);
        acc(0, 8'h53, 8'hc0);
        `CHK({busy_o, sel_o}, 2'b11);
        `CHK({resp_n, orig_n}, 2'b00);
        acc(1, 8'h52, 8'hf0);
        acc(0, 8'h52, 8'h01);
        pin.busy_in <= 1'b0;
        repeat (8) @(posedge clock);
        `CHK(busy_o, 1'b0);
        pin.sel_in <= 1'b0;
        repeat (8) @(posedge clock);
        `CHK({busy_o, out_n}, 2'b10);
        acc(1, 8'h52, 8'h01);
        acc(0, 8'h52, 8'h0c);
        acc(1, 8'h50, 8'h00);
        acc(0, 8'h50, v);
        `CHK(drv, 15);
        acc(0, 8'h53, 8'h10);
        for (int i = 0; i < 300; i++)
        begin
            ramq.push_back({3'b011, i[7:0]});
            pin.peripheral_transfer_request_n_n <= 1'b0;
            @(posedge clock);
            pin.peripheral_transfer_request_n_n <= 1'b1;
            repeat (3 + $urandom % 4) @(posedge clock);
        end
        acc(1, 8'h5c, 8'h2c);
        acc(1, 8'h5d, 8'h00);
        acc(0, 8'h54, 8'h04);
        hi = 8'($urandom);
        acc(0, 8'h5d, hi);
        ramq.push_back({3'b011, 8'h2c});
        pin.peripheral_transfer_request_n_n <= 1'b0;
        @(posedge clock);
        pin.peripheral_transfer_request_n_n <= 1'b1;
        repeat (4) @(posedge clock);
        `CHK({stb, addr_lo}, {1'b1, hi});
        @(posedge clock);
        `CHK(penb_n, 1'b0);
        acc(0, 8'h54, 8'h00);
        host(1'b0, 8'd5);
        host(1'b1, 8'd3);
        acc(0, 8'h53, 8'h00);
        acc(0, 8'h5f, 8'h00);
        acc(1, 8'h53, 8'h00);
        repeat (10) @(posedge clock);
        give_verdict();
    end
endmodule
